// ==== logic/intc_pkg.sv ====
// shared constants, types and vector decode for the prioritized interrupt controller
package intc_pkg;

  localparam int NSRC       = 12;
  localparam int MAIN_SRC_W = 7;
  localparam int EXT_SRC_W  = 5;
  localparam int EXT_PIN_W  = 6;

  // apb request and response bundles
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } apb_req_t;

  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } apb_rsp_t;

  // register byte offsets
  localparam logic [7:0] ENABLE_MASK_OFS  = 8'h00;
  localparam logic [7:0] PRIORITY_SEL_OFS = 8'h04;
  localparam logic [7:0] EXT_ENABLE_OFS   = 8'h08;
  localparam logic [7:0] EXT_PRIORITY_OFS = 8'h0C;
  localparam logic [7:0] TRIG_MODE_OFS    = 8'h10;
  localparam logic [7:0] FLAG_OFS         = 8'h14;
  localparam logic [7:0] STATUS_OFS       = 8'h18;

  // field positions and reset values
  localparam int GATE_BIT      = 7;
  localparam int WDOG_EN_BIT   = 4;
  localparam int FLG_T0_BIT    = 6;
  localparam int FLG_T1_BIT    = 7;
  localparam int ST_BUSY_BIT   = 2;
  localparam int ST_VALID_BIT  = 3;
  localparam logic [7:0] ENABLE_RST   = 8'h00;
  localparam logic [6:0] PRIORITY_RST = 7'h00;
  localparam logic [4:0] EXT_RST      = 5'h00;

  // source order, index 0 wins among equal levels
  localparam logic [3:0] SRC_EXT0 = 4'h0;
  localparam logic [3:0] SRC_T0   = 4'h1;
  localparam logic [3:0] SRC_EXT1 = 4'h2;
  localparam logic [3:0] SRC_T1   = 4'h3;
  localparam logic [3:0] SRC_SER0 = 4'h4;
  localparam logic [3:0] SRC_T2   = 4'h5;
  localparam logic [3:0] SRC_SER1 = 4'h6;
  localparam logic [3:0] SRC_EXT2 = 4'h7;
  localparam logic [3:0] SRC_EXT3 = 4'h8;
  localparam logic [3:0] SRC_EXT4 = 4'h9;
  localparam logic [3:0] SRC_EXT5 = 4'hA;
  localparam logic [3:0] SRC_WDOG = 4'hB;

  // vector addresses
  localparam logic [15:0] VEC_EXT0 = 16'h0003;
  localparam logic [15:0] VEC_T0   = 16'h000B;
  localparam logic [15:0] VEC_EXT1 = 16'h0013;
  localparam logic [15:0] VEC_T1   = 16'h001B;
  localparam logic [15:0] VEC_SER0 = 16'h0023;
  localparam logic [15:0] VEC_T2   = 16'h002B;
  localparam logic [15:0] VEC_SER1 = 16'h003B;
  localparam logic [15:0] VEC_EXT2 = 16'h0043;
  localparam logic [15:0] VEC_EXT3 = 16'h004B;
  localparam logic [15:0] VEC_EXT4 = 16'h0053;
  localparam logic [15:0] VEC_EXT5 = 16'h005B;
  localparam logic [15:0] VEC_WDOG = 16'h0063;

  // machine cycle timing: four clocks each, call lasts four machine cycles
  localparam logic [2:0] CALL_MCYCLES = 3'h4;

  typedef enum logic [1:0] {
    PH_ONE   = 2'b00,
    PH_TWO   = 2'b01,
    PH_THREE = 2'b10,
    PH_FOUR  = 2'b11
  } phase_t;

  typedef enum logic {
    CALL_IDLE = 1'b0,
    CALL_RUN  = 1'b1
  } call_st_t;

  // source index to vector address
  function automatic logic [15:0] vec_of(input logic [3:0] idx);
    case (idx)
      SRC_EXT0: vec_of = VEC_EXT0;
      SRC_T0:   vec_of = VEC_T0;
      SRC_EXT1: vec_of = VEC_EXT1;
      SRC_T1:   vec_of = VEC_T1;
      SRC_SER0: vec_of = VEC_SER0;
      SRC_T2:   vec_of = VEC_T2;
      SRC_SER1: vec_of = VEC_SER1;
      SRC_EXT2: vec_of = VEC_EXT2;
      SRC_EXT3: vec_of = VEC_EXT3;
      SRC_EXT4: vec_of = VEC_EXT4;
      SRC_EXT5: vec_of = VEC_EXT5;
      default:  vec_of = VEC_WDOG;
    endcase
  endfunction

endpackage

// ==== logic/irq_resolver.sv ====
// combinational two-level priority resolver over the twelve sources
`timescale 1ns/10ps
`default_nettype none
module irq_resolver
(
  // requests already gated by enables
  input  wire logic [intc_pkg::NSRC-1:0] req_i,
  input  wire logic [intc_pkg::NSRC-1:0] high_i,
  // winner
  output logic                           valid_o,
  output logic [3:0]                     idx_o,
  output logic                           level_o
);
  import intc_pkg::*;

  logic             hi_any;
  logic             lo_any;
  logic [3:0]       hi_idx;
  logic [3:0]       lo_idx;

  // scan from lowest rank up so the lowest index is the last one kept
  always_comb
  begin
    hi_any = 1'b0;
    lo_any = 1'b0;
    hi_idx = SRC_WDOG;
    lo_idx = SRC_WDOG;
    for (int i = NSRC - 1; i >= 0; i--)
    begin
      if (req_i[i] && high_i[i])
      begin
        hi_any = 1'b1;
        hi_idx = 4'(i);
      end
      if (req_i[i] && !high_i[i])
      begin
        lo_any = 1'b1;
        lo_idx = 4'(i);
      end
    end
    // high level beats low, fixed order breaks ties inside a level
    valid_o = hi_any | lo_any;
    level_o = hi_any;
    idx_o   = hi_any ? hi_idx : lo_idx;  // [RL2]
  end

endmodule // irq_resolver
`default_nettype wire

// ==== logic/prio_intc.sv ====
// prioritized interrupt controller: flags, polling, vector call and apb registers
// Functional notes
// RL1 - each source has a high/low level; lower level never preempts higher service
// RL2 - equal-level ties resolved ext0,t0,ext1,t1,ser0,t2,ser1,ext2..5,watchdog
// RL3 - flags sampled, polled and resolved once every machine cycle
// RL4 - no call while equal or higher level routine is in service
// RL5 - call only in the last machine cycle of the current instruction
// RL6 - no call after enable/priority register writes or handler return; code blocks a call only after register writes, not after handler return
// RL7 - requests are not remembered; each poll is fresh
// RL8 - vectoring to timer 0 or 1 clears its overflow flag
// RL9 - ext0/1 flags cleared on vector only when edge mode; others never
// RL10 - core pushes pc like a long call, no status word, loads vector
// RL11 - fixed vector address per source, 0003h to 0063h
// RL12 - handler return ends current service; plain return leaves it marked
// RL13 - external pins sampled at phase three; flags updated then
// RL14 - timer 0/1 flags set at phase three, polled next machine cycle
// RL15 - call lasts four machine cycles, five from flag to handler
// RL16 - single-interrupt response at most twelve machine cycles
// RL17 - per-source enables plus one global gate masking all
// RL18 - timer 2 request is OR of its overflow and external flags
// RL19 - edge mode sets flag on sampled high then low
// RL20 - watchdog request only while its dedicated enable bit is set
// RL21 - one in-service bit per level, highest cleared on handler return
`timescale 1ns/10ps
`default_nettype none
module prio_intc
(
  // clock and reset
  input  wire logic                     mclk_i,
  input  wire logic                     rst_i,
  // register bus
  input  wire intc_pkg::apb_req_t       apb_req_i,
  output intc_pkg::apb_rsp_t            apb_rsp_o,
  // request sources
  input  wire logic [5:0]               ext_req_pin_n_i,
  input  wire logic                     t0_overflow_i,
  input  wire logic                     t1_overflow_i,
  input  wire logic                     t2_overflow_flag_i,
  input  wire logic                     t2_external_flag_i,
  input  wire logic                     rx_done_flag_i,
  input  wire logic                     tx_done_flag_i,
  input  wire logic                     rx1_done_flag_i,
  input  wire logic                     tx1_done_flag_i,
  input  wire logic                     watchdog_timeout_flag_i,
  // core sequencer
  input  wire logic                     last_cycle_i,
  input  wire logic                     block_instr_i,
  input  wire logic                     return_from_handler_i,
  output intc_pkg::phase_t              phase_o,
  output logic                          long_call_vector_o,
  output logic [15:0]                   vec_addr_o,
  output logic                          call_busy_o,
  output logic [1:0]                    in_service_o,
  output logic                          t0_overflow_flag_o,
  output logic                          t1_overflow_flag_o
);
  import intc_pkg::*;

  phase_t           phase_ff, nxt_phase;
  apb_rsp_t         rsp_ff, nxt_rsp;
  logic [7:0]       enable_mask_reg_ff, nxt_enable_mask_reg;
  logic [6:0]       priority_select_reg_ff, nxt_priority_select_reg;
  logic [4:0]       ext_enable_mask_reg_ff, nxt_ext_enable_mask_reg;
  logic [4:0]       ext_priority_reg_ff, nxt_ext_priority_reg;
  logic [1:0]       edge_mode_ff, nxt_edge_mode;
  logic [5:0]       ext_flag_ff, nxt_ext_flag;
  logic [5:0]       pin_prev_ff, nxt_pin_prev;
  logic             t0_flag_ff, nxt_t0_flag;
  logic             t1_flag_ff, nxt_t1_flag;
  logic             regw_ff, nxt_regw;
  logic [NSRC-1:0]  poll_ff, nxt_poll;
  call_st_t         st_ff, nxt_st;
  logic [2:0]       mcnt_ff, nxt_mcnt;
  logic [1:0]       isr_ff, nxt_isr;
  logic             call_ff, nxt_call;
  logic [15:0]      vaddr_ff, nxt_vaddr;
  logic             busy_ff, nxt_busy;
  logic             wr_en, flag_wr, prio_wr, issue, lvl_ok;
  logic [NSRC-1:0]  req_raw, req_en;
  logic             win_valid, win_level;
  logic [3:0]       win_idx;
  logic [5:0]       pin_hi;

  // machine cycle phase counter, free running
  always_comb
  begin
    nxt_phase = phase_t'(phase_ff + 2'h1);
  end

  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
      phase_ff <= PH_ONE;
    else
      phase_ff <= nxt_phase;
  end

  // request vector in fixed order; gate and enables applied below
  always_comb
  begin
    req_raw[SRC_EXT0] = ext_flag_ff[0];
    req_raw[SRC_T0]   = t0_flag_ff;
    req_raw[SRC_EXT1] = ext_flag_ff[1];
    req_raw[SRC_T1]   = t1_flag_ff;
    req_raw[SRC_SER0] = rx_done_flag_i | tx_done_flag_i;
    req_raw[SRC_T2]   = t2_overflow_flag_i | t2_external_flag_i;   // [RL18]
    req_raw[SRC_SER1] = rx1_done_flag_i | tx1_done_flag_i;
    req_raw[SRC_EXT2] = ext_flag_ff[2];
    req_raw[SRC_EXT3] = ext_flag_ff[3];
    req_raw[SRC_EXT4] = ext_flag_ff[4];
    req_raw[SRC_EXT5] = ext_flag_ff[5];
    req_raw[SRC_WDOG] = watchdog_timeout_flag_i;  // gated by bit WDOG_EN_BIT [RL20]
    req_en = req_raw & {ext_enable_mask_reg_ff, enable_mask_reg_ff[MAIN_SRC_W-1:0]}
             & {NSRC{enable_mask_reg_ff[GATE_BIT]}};  // [RL17]
  end

  // apb slave: one wait state so every response bit leaves a flop
  always_comb
  begin
    wr_en   = apb_req_i.psel && apb_req_i.penable && apb_req_i.pwrite && rsp_ff.pready;
    flag_wr = wr_en && (apb_req_i.paddr == FLAG_OFS);
    prio_wr = wr_en && (apb_req_i.paddr inside {ENABLE_MASK_OFS, PRIORITY_SEL_OFS,
                                                EXT_ENABLE_OFS, EXT_PRIORITY_OFS});
    nxt_rsp = '0;
    nxt_rsp.prdata = rsp_ff.prdata;
    if (apb_req_i.psel && apb_req_i.penable && !rsp_ff.pready)
    begin
      nxt_rsp.pready = 1'b1;
      nxt_rsp.prdata = '0;
      case (apb_req_i.paddr)
        ENABLE_MASK_OFS:  nxt_rsp.prdata[7:0] = enable_mask_reg_ff;
        PRIORITY_SEL_OFS: nxt_rsp.prdata[6:0] = priority_select_reg_ff;
        EXT_ENABLE_OFS:   nxt_rsp.prdata[4:0] = ext_enable_mask_reg_ff;
        EXT_PRIORITY_OFS: nxt_rsp.prdata[4:0] = ext_priority_reg_ff;
        TRIG_MODE_OFS:    nxt_rsp.prdata[1:0] = edge_mode_ff;
        FLAG_OFS:         nxt_rsp.prdata[7:0] = {t1_flag_ff, t0_flag_ff, ext_flag_ff};
        STATUS_OFS:       nxt_rsp.prdata[7:0] = {win_idx, win_valid, busy_ff, isr_ff};
        default:          nxt_rsp.pslverr     = 1'b1;
      endcase
    end
    nxt_enable_mask_reg     = enable_mask_reg_ff;
    nxt_priority_select_reg = priority_select_reg_ff;
    nxt_ext_enable_mask_reg = ext_enable_mask_reg_ff;
    nxt_ext_priority_reg    = ext_priority_reg_ff;
    nxt_edge_mode           = edge_mode_ff;
    if (wr_en)
    begin
      case (apb_req_i.paddr)
        ENABLE_MASK_OFS:  nxt_enable_mask_reg     = apb_req_i.pwdata[7:0];
        PRIORITY_SEL_OFS: nxt_priority_select_reg = apb_req_i.pwdata[6:0];  // [RL1]
        EXT_ENABLE_OFS:   nxt_ext_enable_mask_reg = apb_req_i.pwdata[4:0];
        EXT_PRIORITY_OFS: nxt_ext_priority_reg    = apb_req_i.pwdata[4:0];
        TRIG_MODE_OFS:    nxt_edge_mode           = apb_req_i.pwdata[1:0];
        default:          nxt_edge_mode           = edge_mode_ff;
      endcase
    end
  end

  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      rsp_ff                 <= '0;
      enable_mask_reg_ff     <= ENABLE_RST;
      priority_select_reg_ff <= PRIORITY_RST;
      ext_enable_mask_reg_ff <= EXT_RST;
      ext_priority_reg_ff    <= EXT_RST;
      edge_mode_ff           <= 2'h0;
    end
    else
    begin
      rsp_ff                 <= nxt_rsp;
      enable_mask_reg_ff     <= nxt_enable_mask_reg;
      priority_select_reg_ff <= nxt_priority_select_reg;
      ext_enable_mask_reg_ff <= nxt_ext_enable_mask_reg;
      ext_priority_reg_ff    <= nxt_ext_priority_reg;
      edge_mode_ff           <= nxt_edge_mode;
    end
  end

  // request flags: software write, then vector clear, then hardware set, so a set wins
  always_comb
  begin
    pin_hi       = ~ext_req_pin_n_i;
    nxt_ext_flag = ext_flag_ff;
    nxt_t0_flag  = t0_flag_ff;
    nxt_t1_flag  = t1_flag_ff;
    nxt_pin_prev = pin_prev_ff;
    if (flag_wr)
    begin
      nxt_ext_flag = apb_req_i.pwdata[EXT_PIN_W-1:0];
      nxt_t0_flag  = apb_req_i.pwdata[FLG_T0_BIT];
      nxt_t1_flag  = apb_req_i.pwdata[FLG_T1_BIT];
    end
    if (issue)
    begin
      if (win_idx == SRC_T0) nxt_t0_flag = 1'b0;                            // [RL8]
      if (win_idx == SRC_T1) nxt_t1_flag = 1'b0;                            // [RL8]
      if (win_idx == SRC_EXT0 && edge_mode_ff[0]) nxt_ext_flag[0] = 1'b0;   // [RL9]
      if (win_idx == SRC_EXT1 && edge_mode_ff[1]) nxt_ext_flag[1] = 1'b0;   // [RL9]
    end
    // pins are active low; a high-then-low sample pair is an edge
    if (phase_ff == PH_THREE)
    begin
      nxt_pin_prev = ext_req_pin_n_i;  // [RL13]
      for (int i = 0; i < EXT_PIN_W; i++)
      begin
        if (pin_prev_ff[i] && !ext_req_pin_n_i[i]) nxt_ext_flag[i] = 1'b1;  // [RL19]
      end
      // level mode ext0/1 track the pin and are never cleared by vectoring
      if (!edge_mode_ff[0]) nxt_ext_flag[0] = pin_hi[0];  // [RL13]
      if (!edge_mode_ff[1]) nxt_ext_flag[1] = pin_hi[1];
      if (t0_overflow_i) nxt_t0_flag = 1'b1;  // [RL14]
      if (t1_overflow_i) nxt_t1_flag = 1'b1;  // [RL14]
    end
  end

  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      ext_flag_ff <= 6'h00;
      pin_prev_ff <= 6'h3F;
      t0_flag_ff  <= 1'b0;
      t1_flag_ff  <= 1'b0;
    end
    else
    begin
      ext_flag_ff <= nxt_ext_flag;
      pin_prev_ff <= nxt_pin_prev;
      t0_flag_ff  <= nxt_t0_flag;
      t1_flag_ff  <= nxt_t1_flag;
    end
  end

  irq_resolver u_resolver
  (
    .req_i   (poll_ff),
    .high_i  ({ext_priority_reg_ff, priority_select_reg_ff}),
    .valid_o (win_valid),
    .idx_o   (win_idx),
    .level_o (win_level)
  );

  // poll at the end of phase one so a phase-three set is seen next machine cycle;
  // decide at the end of phase four; a dropped request is simply re-polled
  always_comb
  begin
    lvl_ok  = win_level ? !isr_ff[1] : (isr_ff == 2'b00);  // [RL4] [RL1]
    issue   = (phase_ff == PH_FOUR) && (st_ff == CALL_IDLE) && win_valid && lvl_ok
              && last_cycle_i && !block_instr_i && !regw_ff && !prio_wr;  // [RL5] [RL6]
    nxt_poll  = (phase_ff == PH_ONE) ? req_en : poll_ff;  // [RL3] [RL7] [RL16]
    nxt_regw  = (prio_wr || regw_ff) && (phase_ff != PH_FOUR);
    nxt_st    = st_ff;
    nxt_mcnt  = mcnt_ff;
    nxt_isr   = isr_ff;
    nxt_call  = issue;
    nxt_vaddr = issue ? vec_of(win_idx) : vaddr_ff;  // [RL11] [RL10]
    // handler return closes the highest open level; plain return is not seen
    if (return_from_handler_i)
    begin
      if (isr_ff[1]) nxt_isr[1] = 1'b0;  // [RL12] [RL21]
      else nxt_isr[0] = 1'b0;
    end
    case (st_ff)
      CALL_IDLE:
      begin
        if (issue)
        begin
          nxt_st   = CALL_RUN;
          nxt_mcnt = CALL_MCYCLES;  // [RL15]
          nxt_isr  = nxt_isr | {win_level, !win_level};  // [RL21]
        end
      end
      CALL_RUN:
      begin
        if (phase_ff == PH_FOUR)
        begin
          nxt_mcnt = 3'(mcnt_ff - 3'h1);
          if (mcnt_ff == 3'h1) nxt_st = CALL_IDLE;  // [RL15]
        end
      end
      default: nxt_st = CALL_IDLE;
    endcase
    nxt_busy = (nxt_st == CALL_RUN);
  end

  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      poll_ff  <= '0;
      regw_ff  <= 1'b0;
      st_ff    <= CALL_IDLE;
      mcnt_ff  <= 3'h0;
      isr_ff   <= 2'h0;
      call_ff  <= 1'b0;
      vaddr_ff <= 16'h0000;
      busy_ff  <= 1'b0;
    end
    else
    begin
      poll_ff  <= nxt_poll;
      regw_ff  <= nxt_regw;
      st_ff    <= nxt_st;
      mcnt_ff  <= nxt_mcnt;
      isr_ff   <= nxt_isr;
      call_ff  <= nxt_call;
      vaddr_ff <= nxt_vaddr;
      busy_ff  <= nxt_busy;
    end
  end

  // outputs straight from flops
  assign apb_rsp_o          = rsp_ff;
  assign phase_o            = phase_ff;
  assign long_call_vector_o = call_ff;
  assign vec_addr_o         = vaddr_ff;
  assign call_busy_o        = busy_ff;
  assign in_service_o       = isr_ff;
  assign t0_overflow_flag_o = t0_flag_ff;
  assign t1_overflow_flag_o = t1_flag_ff;

  // checks on the call path, flag timing and handler return
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);

  sequence s_call_cond;
    $past(last_cycle_i) && $past(phase_ff) == PH_FOUR;
  endsequence
  property p_call_last;
    long_call_vector_o |-> s_call_cond;
  endproperty
  a_call_last: assert property (p_call_last) else $error("call outside last cycle"); // [RL5]
  property p_call_blocked;
    long_call_vector_o |-> !$past(block_instr_i) && !$past(prio_wr);
  endproperty
  a_call_blocked: assert property (p_call_blocked) else $error("call after block"); // [RL6]
  property p_call_level;
    long_call_vector_o |-> !$past(isr_ff[1]) && ($past(win_level) || !$past(isr_ff[0]));
  endproperty
  a_call_level: assert property (p_call_level) else $error("call preempts service"); // [RL4]
  property p_call_len;
    long_call_vector_o |-> call_busy_o [*8] ##1 call_busy_o [*8] ##1 !call_busy_o;
  endproperty
  a_call_len: assert property (p_call_len) else $error("call too short"); // [RL15]
  property p_t0_clear;
    long_call_vector_o && vec_addr_o == VEC_T0 |-> !t0_overflow_flag_o;
  endproperty
  a_t0_clear: assert property (p_t0_clear) else $error("t0 flag kept"); // [RL8]
  property p_ext0_clear;
    long_call_vector_o && vec_addr_o == VEC_EXT0 && edge_mode_ff[0] |-> !ext_flag_ff[0];
  endproperty
  a_ext0_clear: assert property (p_ext0_clear) else $error("ext0 flag kept"); // [RL9]
  property p_ext_phase;
    $changed(ext_flag_ff) && !$past(flag_wr) && !$past(issue)
      |-> $past(phase_ff) == PH_THREE;
  endproperty
  a_ext_phase: assert property (p_ext_phase) else $error("ext flag off phase"); // [RL13]
  property p_ret_clear;
    return_from_handler_i && isr_ff == 2'b11 && !issue |=> isr_ff == 2'b01;
  endproperty
  a_ret_clear: assert property (p_ret_clear) else $error("return kept level"); // [RL12]
  property p_gate;
    long_call_vector_o |-> $past(poll_ff) != '0 && enable_mask_reg_ff[GATE_BIT];
  endproperty
  a_gate: assert property (p_gate) else $error("call while gated"); // [RL17]

endmodule // prio_intc
`default_nettype wire

// ==== tb/core_model.sv ====
// behavioural core sequencer that marks instruction boundaries for the controller
`timescale 1ns/10ps
`default_nettype none
module core_model
#(
  parameter int LEN = 2
)
(
  // clock and reset
  input  wire logic             mclk_i,
  input  wire logic             rst_i,
  // controller side
  input  wire intc_pkg::phase_t phase_i,
  input  wire logic             busy_i,
  input  wire logic             blk_i,
  output logic                  last_cycle_o,
  output logic                  block_instr_o
);
  import intc_pkg::*;

  logic [2:0] cnt_ff;
  logic [2:0] nxt_cnt;

  // machine cycle count within the instruction; frozen while a call runs
  always_comb
  begin
    nxt_cnt = cnt_ff;
    if (phase_i == PH_FOUR && !busy_i)
    begin
      nxt_cnt = (cnt_ff == 3'(LEN - 1)) ? 3'h0 : cnt_ff + 3'h1;
    end
  end

  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
      cnt_ff <= 3'h0;
    else
      cnt_ff <= nxt_cnt;
  end

  // boundary only outside a call, so a call never starts inside another
  assign last_cycle_o  = !busy_i && (cnt_ff == 3'(LEN - 1));
  assign block_instr_o = last_cycle_o & blk_i;
endmodule // core_model
`default_nettype wire

// ==== tb/prio_intc_test.sv ====
// self-checking bench for the prioritized interrupt controller
`timescale 1ns/10ps
`default_nettype none
module prio_intc_test;
  import intc_pkg::*;

  logic mclk_i, rst_i, t0ov, t1ov, t2x, rx, wd, ret, blk, last, blki, call, busy, t0f, t1f, e;
  logic [5:0] pins;
  logic [15:0] vec;
  logic [1:0] insvc;
  logic [31:0] q;
  phase_t ph;
  apb_req_t req;
  apb_rsp_t rsp;
  int num_errors, compares;

  prio_intc dut (.mclk_i(mclk_i), .rst_i(rst_i), .apb_req_i(req), .apb_rsp_o(rsp),
    .ext_req_pin_n_i(pins), .t0_overflow_i(t0ov), .t1_overflow_i(t1ov),
    .t2_overflow_flag_i(1'b0), .t2_external_flag_i(t2x), .rx_done_flag_i(rx),
    .tx_done_flag_i(1'b0), .rx1_done_flag_i(1'b0), .tx1_done_flag_i(1'b0),
    .watchdog_timeout_flag_i(wd), .last_cycle_i(last), .block_instr_i(blki),
    .return_from_handler_i(ret), .phase_o(ph), .long_call_vector_o(call),
    .vec_addr_o(vec), .call_busy_o(busy), .in_service_o(insvc),
    .t0_overflow_flag_o(t0f), .t1_overflow_flag_o(t1f));

  core_model #(.LEN(2)) core (.mclk_i(mclk_i), .rst_i(rst_i), .phase_i(ph), .busy_i(busy),
    .blk_i(blk), .last_cycle_o(last), .block_instr_o(blki));

  // clock at 250 MHz
  initial
  begin
    mclk_i = 1'b0;
    forever #2 mclk_i = ~mclk_i;
  end

  task automatic print_verdict();
    $display("compares %0d num_errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    compares++;
    if (got !== ex)
    begin
      num_errors++;
      $display("Error %s expected %h seen %h", nm, ex, got);
    end
  endtask

  // one apb transfer held until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge mclk_i);
    req <= '{1'b1, 1'b0, wr, a, d};
    @(posedge mclk_i);
    req.penable <= 1'b1;
    do
    begin
      @(posedge mclk_i);
      n++;
    end while (rsp.pready !== 1'b1 && n < 20);
    if (n >= 20)
    begin
      chk("pready", 1, 0);
      print_verdict();
    end
    q = rsp.prdata;
    e = rsp.pslverr;
    req <= '0;
  endtask

  // wait for a call, bounded by the single-interrupt worst case of 48 clocks
  task automatic wait_call(input logic [15:0] v, input logic [1:0] svc);
    int n;
    n = 0;
    do
    begin
      @(posedge mclk_i);
      n++;
    end while (call !== 1'b1 && n <= 48);
    if (n > 48)
    begin
      chk("call_latency", 48, n);
      print_verdict();
    end
    chk("vector", {16'h0000, v}, {16'h0000, vec});
    n = 0;
    while (busy === 1'b1 && n < 40)
    begin
      n++;
      @(posedge mclk_i);
    end
    chk("busy_cycles", 16, n);
    chk("in_service", svc, insvc);
  endtask

  task automatic no_call(input int n);
    repeat (n)
    begin
      @(posedge mclk_i);
      chk("no_call", 0, call);
    end
  endtask

  task automatic do_ret(input logic [1:0] svc);
    @(posedge mclk_i);
    ret <= 1'b1;
    @(posedge mclk_i);
    ret <= 1'b0;
    repeat (2) @(posedge mclk_i);
    chk("in_service_ret", svc, insvc);
  endtask

  // main sequence
  initial
  begin
    rst_i = 1'b1; req = '0; pins = 6'h3F; t0ov = 0; t2x = 0; rx = 0; wd = 0; ret = 0; blk = 0;
    t1ov = 1'b0;
    num_errors = 0;
    compares = 0;
    repeat (3) @(posedge mclk_i);
    rst_i <= 1'b0;
    apb(1'b0, ENABLE_MASK_OFS, 32'h0);
    chk("enable_rst", 32'h0, q);
    apb(1'b0, 8'h40, 32'h0);
    chk("unmapped_err", 1, e);
    apb(1'b1, ENABLE_MASK_OFS, 32'hFF);
    apb(1'b1, EXT_ENABLE_OFS, 32'h0F);
    apb(1'b1, TRIG_MODE_OFS, 32'h01);
    apb(1'b0, ENABLE_MASK_OFS, 32'h0);
    chk("enable_rd", 32'hFF, q);
    // edge on pin 0
    repeat (8) @(posedge mclk_i);
    pins[0] <= 1'b0;
    wait_call(16'h0003, 2'b01);
    apb(1'b0, FLAG_OFS, 32'h0);
    chk("ext0_flag", 0, q[0]);
    pins[0] <= 1'b1;
    do_ret(2'b00);
    // timer 0 and level pin 1 together at low level
    pins[1] <= 1'b0;
    t0ov <= 1'b1;
    repeat (4) @(posedge mclk_i);
    t0ov <= 1'b0;
    wait_call(16'h000B, 2'b01);
    chk("t0_flag", 0, t0f);
    do_ret(2'b00);
    wait_call(16'h0013, 2'b01);
    // high level serial preempts low level service
    apb(1'b1, PRIORITY_SEL_OFS, 32'h10);
    rx <= 1'b1;
    wait_call(16'h0023, 2'b11);
    rx <= 1'b0;
    do_ret(2'b01);
    no_call(40);
    pins[1] <= 1'b1;
    repeat (8) @(posedge mclk_i);
    do_ret(2'b00);
    // blocked boundary, dropped request, global gate
    blk <= 1'b1;
    rx <= 1'b1;
    no_call(40);
    rx <= 1'b0;
    repeat (8) @(posedge mclk_i);
    blk <= 1'b0;
    no_call(20);
    apb(1'b1, ENABLE_MASK_OFS, 32'h7F);
    rx <= 1'b1;
    no_call(40);
    apb(1'b1, ENABLE_MASK_OFS, 32'hFF);
    wait_call(16'h0023, 2'b10);
    rx <= 1'b0;
    do_ret(2'b00);
    // watchdog needs its own enable bit
    wd <= 1'b1;
    no_call(40);
    apb(1'b1, EXT_ENABLE_OFS, 32'h1F);
    wait_call(16'h0063, 2'b01);
    wd <= 1'b0;
    do_ret(2'b00);
    // timer 2 through its external event flag
    t2x <= 1'b1;
    wait_call(16'h002B, 2'b01);
    t2x <= 1'b0;
    do_ret(2'b00);
    // timer 1 overflow, flag dropped by its own vector call
    t1ov <= 1'b1;
    repeat (4) @(posedge mclk_i);
    t1ov <= 1'b0;
    wait_call(16'h001B, 2'b01);
    chk("t1_flag", 0, t1f);
    do_ret(2'b00);
    print_verdict();
  end
endmodule // prio_intc_test
`default_nettype wire
